// [design/oft_retry_timer.sv]
// output overvoltage fault hold, shutdown and restart timing
// Summary of operation
// - the restart limit comes from bits 5:3, codes 0 to 6 give that many tries and 7 is endless.
// - once the tries are used up and the fault remains, the output goes off and stays off.
// - a latched off state ends only on reset or on a power cycle or bias loss event.
// - restarts are spaced by 252 to 2604 ms picked by the 3-bit delay code.
// - in hold mode the output is disabled only after a hold of 10 ms doubled per code; shut down and off until clear disable at once.
// - one 3-bit code picks both the hold delay and the restart gap as a fixed pair.
// - bits 7:6 pick ignore, hold then retry, shut down and retry, or off until clear.
//
// Implementation choices: the address map and the strobed register port.
`include "oft_consts.svh"
module oft_retry_timer #(
  parameter int CYCLES_PER_MS = `OFT_CLK_HZ / `OFT_MS_PER_S
) (
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  // register port
  input  wire oft_pkg::oft_bus_s bus,
  output logic [7:0]            rdata,
  // fault side
  input  wire logic             fault_in,
  input  wire logic             power_cycle,
  input  wire logic             bias_lost,
  output logic                  output_en,
  output logic                  latched_off,
  // interrupt
  output logic                  irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // hold delay in ms, 10 ms doubled per code
  function automatic logic [11:0] hold_ms(input logic [2:0] code);
    hold_ms = `OFT_HOLD_BASE_MS << code;
  endfunction

  // restart gap in ms
  function automatic logic [11:0] gap_ms(input logic [2:0] code);
    unique case (code)
      3'h0: gap_ms = `OFT_GAP0_MS;
      3'h1: gap_ms = `OFT_GAP1_MS;
      3'h2: gap_ms = `OFT_GAP2_MS;
      3'h3: gap_ms = `OFT_GAP3_MS;
      3'h4: gap_ms = `OFT_GAP4_MS;
      3'h5: gap_ms = `OFT_GAP5_MS;
      3'h6: gap_ms = `OFT_GAP6_MS;
      3'h7: gap_ms = `OFT_GAP7_MS;
    endcase
  endfunction

  // true when no further restart is allowed
  function automatic logic tries_spent(input logic [2:0] lim, input logic [2:0] done);
    tries_spent = (lim != `OFT_RETRY_ENDLESS) && (done >= lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  oft_pkg::oft_regs_s r_ff;
  oft_pkg::oft_regs_s nxt_r;

  localparam logic [13:0] TICK_LAST = 14'(CYCLES_PER_MS - 1);

  logic [1:0] resp;
  logic [2:0] lim;
  logic [2:0] dcode;
  logic [3:0] ev;
  logic       tick;
  logic       expired;
  logic       clr_evt;

  // decode of the action register and timer tick
  always_comb begin
    resp    = r_ff.action[`OFT_RESP_HI:`OFT_RESP_LO];
    lim     = r_ff.action[`OFT_RETRY_HI:`OFT_RETRY_LO];
    dcode   = r_ff.action[`OFT_DELAY_HI:`OFT_DELAY_LO];
    tick    = (r_ff.pre == TICK_LAST);
    expired = tick && (r_ff.ms <= 12'h001);
    clr_evt = power_cycle || bias_lost;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_r = r_ff;
    ev    = 4'h0;
    // millisecond prescaler and countdown
    nxt_r.pre = tick ? 14'h0000 : r_ff.pre + 14'h0001;
    if (tick && (r_ff.ms != 12'h000)) begin
      nxt_r.ms = r_ff.ms - 12'h001;
    end

    // fault sequencer
    unique case (r_ff.st)
      oft_pkg::OFT_RUN, oft_pkg::OFT_IGNORE: begin
        nxt_r.out_en = 1'b1;
        nxt_r.st     = (resp == `OFT_RESP_IGNORE) ? oft_pkg::OFT_IGNORE : oft_pkg::OFT_RUN;
        if (fault_in && (resp != `OFT_RESP_IGNORE)) begin
          ev[`OFT_EV_FAULT] = 1'b1;
          unique case (resp)
            `OFT_RESP_HOLD: begin
              nxt_r.st  = oft_pkg::OFT_HOLD;
              nxt_r.ms  = hold_ms(dcode);
              nxt_r.pre = 14'h0000;
            end
            `OFT_RESP_SHUT: begin
              nxt_r.out_en         = 1'b0;
              ev[`OFT_EV_DISABLE]  = 1'b1;
              nxt_r.pre            = 14'h0000;
              nxt_r.ms             = gap_ms(dcode);
              nxt_r.st             = oft_pkg::OFT_OFFWAIT;
              if (tries_spent(lim, r_ff.tries)) begin
                nxt_r.st        = oft_pkg::OFT_LATCHED;
                nxt_r.latched   = 1'b1;
                ev[`OFT_EV_LATCH] = 1'b1;
              end
            end
            default: begin
              nxt_r.out_en        = 1'b0;
              ev[`OFT_EV_DISABLE] = 1'b1;
              nxt_r.st            = oft_pkg::OFT_WAITCLR;
            end
          endcase
        end
      end
      oft_pkg::OFT_HOLD: begin
        // output stays on during the hold
        if (!fault_in) begin
          nxt_r.st = oft_pkg::OFT_RUN;
        end else if (expired) begin
          nxt_r.out_en        = 1'b0;
          ev[`OFT_EV_DISABLE] = 1'b1;
          nxt_r.pre           = 14'h0000;
          nxt_r.ms            = gap_ms(dcode);
          nxt_r.st            = oft_pkg::OFT_OFFWAIT;
          if (tries_spent(lim, r_ff.tries)) begin
            nxt_r.st          = oft_pkg::OFT_LATCHED;
            nxt_r.latched     = 1'b1;
            ev[`OFT_EV_LATCH] = 1'b1;
          end
        end
      end
      oft_pkg::OFT_OFFWAIT: begin
        // restart once the gap has elapsed
        if (expired) begin
          nxt_r.out_en        = 1'b1;
          ev[`OFT_EV_RESTART] = 1'b1;
          nxt_r.st            = oft_pkg::OFT_RUN;
          if (lim != `OFT_RETRY_ENDLESS) begin
            nxt_r.tries = r_ff.tries + 3'h1;
          end
        end
      end
      oft_pkg::OFT_WAITCLR: begin
        // output re-enabled once the fault is gone
        if (!fault_in) begin
          nxt_r.out_en = 1'b1;
          nxt_r.st     = oft_pkg::OFT_RUN;
        end
      end
      oft_pkg::OFT_LATCHED: begin
        nxt_r.out_en = 1'b0;
      end
    endcase

    // latched fault cleared by power cycle or bias loss
    if (clr_evt) begin
      nxt_r.st      = oft_pkg::OFT_RUN;
      nxt_r.latched = 1'b0;
      nxt_r.out_en  = 1'b1;
      nxt_r.tries   = 3'h0;
      nxt_r.ms      = 12'h000;
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `OFT_ADDR_ACTION: nxt_r.action = bus.wdata;
        `OFT_ADDR_ENABLE: nxt_r.irq_en = bus.wdata[3:0];
        default: ;
      endcase
    end

    // sticky status, a new event wins over the clear
    nxt_r.status = r_ff.status | ev;
    if (bus.wr && (bus.addr == `OFT_ADDR_CLEAR)) begin
      nxt_r.status = (r_ff.status & ~bus.wdata[3:0]) | ev;
    end
    nxt_r.irq = |(nxt_r.status & nxt_r.irq_en);

    // register reads, data valid the cycle after the strobe
    nxt_r.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `OFT_ADDR_ACTION: nxt_r.rdata = r_ff.action;
        `OFT_ADDR_STATUS: nxt_r.rdata = {4'h0, r_ff.status};
        `OFT_ADDR_ENABLE: nxt_r.rdata = {4'h0, r_ff.irq_en};
        `OFT_ADDR_STATE:  nxt_r.rdata = {r_ff.latched, r_ff.out_en, 3'h0, r_ff.tries};
        default:          nxt_r.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // synchronous reset clears the latch and the try count
  always_ff @(posedge clk) begin
    if (reset) begin
      r_ff         <= '0;
      r_ff.st      <= oft_pkg::OFT_RUN;
      r_ff.action  <= `OFT_ACTION_RST;
      r_ff.out_en  <= 1'b1;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  // outputs straight from flops
  assign rdata       = r_ff.rdata;
  assign output_en   = r_ff.out_en;
  assign latched_off = r_ff.latched;
  assign irq         = r_ff.irq;

endmodule

// [design/oft_consts.svh]
// constants of the output fault retry timer
`ifndef OFT_CONSTS_SVH
`define OFT_CONSTS_SVH
`define OFT_CLK_HZ        10000000
`define OFT_MS_PER_S      1000
`define OFT_ADDR_ACTION   4'h0
`define OFT_ADDR_STATUS   4'h1
`define OFT_ADDR_CLEAR    4'h2
`define OFT_ADDR_ENABLE   4'h3
`define OFT_ADDR_STATE    4'h4
`define OFT_ACTION_RST    8'h80
`define OFT_RESP_HI       7
`define OFT_RESP_LO       6
`define OFT_RETRY_HI      5
`define OFT_RETRY_LO      3
`define OFT_DELAY_HI      2
`define OFT_DELAY_LO      0
`define OFT_RETRY_ENDLESS 3'h7
`define OFT_RESP_IGNORE   2'h0
`define OFT_RESP_HOLD     2'h1
`define OFT_RESP_SHUT     2'h2
`define OFT_RESP_WAITCLR  2'h3
`define OFT_EV_FAULT      0
`define OFT_EV_DISABLE    1
`define OFT_EV_RESTART    2
`define OFT_EV_LATCH      3
`define OFT_HOLD_BASE_MS  12'h00A
`define OFT_GAP0_MS       12'h0FC
`define OFT_GAP1_MS       12'h22E
`define OFT_GAP2_MS       12'h39C
`define OFT_GAP3_MS       12'h4EC
`define OFT_GAP4_MS       12'h63C
`define OFT_GAP5_MS       12'h78C
`define OFT_GAP6_MS       12'h8DC
`define OFT_GAP7_MS       12'hA2C
`endif

// [design/oft_pkg.sv]
// types of the output fault retry timer
package oft_pkg;
  typedef enum logic [5:0] {
    OFT_RUN     = 6'h01,
    OFT_HOLD    = 6'h02,
    OFT_OFFWAIT = 6'h04,
    OFT_LATCHED = 6'h08,
    OFT_WAITCLR = 6'h10,
    OFT_IGNORE  = 6'h20
  } oft_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } oft_bus_s;

  typedef struct packed {
    oft_state_e  st;
    logic [7:0]  action;
    logic [2:0]  tries;
    logic [13:0] pre;
    logic [11:0] ms;
    logic [3:0]  status;
    logic [3:0]  irq_en;
    logic        out_en;
    logic        latched;
    logic        irq;
    logic [7:0]  rdata;
  } oft_regs_s;
endpackage

// [sim/oft_retry_timer_asserts.sv]
// assertion checker for the output fault retry timer
module oft_retry_timer_asserts (
  // clock and reset
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              ce,
  // register port
  input wire oft_pkg::oft_bus_s bus,
  input wire logic [7:0]        rdata,
  // fault side
  input wire logic              fault_in,
  input wire logic              power_cycle,
  input wire logic              bias_lost,
  input wire logic              output_en,
  input wire logic              latched_off,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] act_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // shadow of the action register, seen from bus writes
  always_ff @(posedge clk) begin
    if (reset)
      act_ff <= 8'h80;
    else if (ce && bus.wr && bus.addr == 4'h0)
      act_ff <= bus.wdata;
  end
  ////////////////////////////////////////
  AST_RST_OUT: assert property ($fell(reset) |-> output_en && !latched_off && !irq && rdata == 8'h00)
    else $error("outputs wrong after reset");
  AST_LATCH_KEEP: assert property (latched_off && !power_cycle && !bias_lost |=> latched_off)
    else $error("latched off state left early");
  AST_LATCH_OFF: assert property (latched_off |-> !output_en)
    else $error("output on while latched");
  AST_CLEAR: assert property (ce && (power_cycle || bias_lost) |=> !latched_off && output_en)
    else $error("clear event did not restore output");
  AST_SHUT: assert property (ce && act_ff[7:6] == 2'h2 && fault_in && output_en |=> !output_en)
    else $error("shutdown mode kept output on");
  AST_IGNORE: assert property (ce && act_ff[7:6] == 2'h0 && output_en |=> output_en)
    else $error("ignore mode turned output off");
  AST_HOLD: assert property (ce && act_ff[7:6] == 2'h1 && $rose(fault_in) && output_en |=> output_en [*8])
    else $error("hold mode turned output off early");
  AST_WAITCLR: assert property (ce && act_ff[7:6] == 2'h3 && fault_in && output_en |=> !output_en)
    else $error("wait mode kept output on");
endmodule

// [sim/oft_stage_model.sv]
// power stage model whose detector reports the commanded overvoltage
module oft_stage_model (
  // clock
  input  wire logic clk,
  // overvoltage command from the bench
  input  wire logic ov_cmd,
  // detector output
  output logic      fault_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // detector answers one cycle late, starts clean
  initial fault_in = 1'b0;
  always @(posedge clk) fault_in <= ov_cmd;
endmodule

// [sim/testbench.sv]
// testbench of the output fault retry timer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 2;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              ce = 1'b1;
  logic              ov_cmd = 1'b0;
  logic              power_cycle = 1'b0;
  logic              bias_lost = 1'b0;
  oft_pkg::oft_bus_s bus = '0;
  logic [7:0]        rdata;
  logic              fault_in, output_en, latched_off, irq;
  int                failures = 0;
  int                n_tests = 0;
  int                n;
  // clock and units
  always #50 clk = ~clk;
  oft_stage_model oft_stage_model_inst (.clk(clk), .ov_cmd(ov_cmd), .fault_in(fault_in));
  oft_retry_timer #(.CYCLES_PER_MS(CPM)) oft_retry_timer_inst (.clk(clk), .reset(reset),
    .ce(ce), .bus(bus), .rdata(rdata), .fault_in(fault_in), .power_cycle(power_cycle),
    .bias_lost(bias_lost), .output_en(output_en), .latched_off(latched_off), .irq(irq));
  ////////////////////////////////////////
  // compare, bus and timing helpers
  task automatic check(input string what, input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(what, {4'h0, rdata}, {4'h0, exp});
  endtask
  task automatic span(input logic lvl);
    for (n = 0; output_en !== lvl && n < 9000; n++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic near(input string what, input int exp);
    check(what, {11'h000, n >= exp - 3 && n <= exp + 3}, 12'h001);
  endtask
  task automatic pulse_ov(input logic lvl);
    @(posedge clk);
    ov_cmd <= lvl;
  endtask
  ////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(4'h0, 8'h80, "action");
    @(posedge clk);
    #1 check("rdata idle", {4'h0, rdata}, 12'h000);
    rd(4'h4, 8'h40, "state");
    rd(4'h5, 8'h00, "unmapped");
  endtask
  task automatic t_retry_once();
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h88);
    pulse_ov(1'b1);
    span(1'b0);
    span(1'b1);
    near("gap0", 252 * CPM);
    check("irq", {11'h000, irq}, 12'h001);
    repeat (200) @(posedge clk);
    pulse_ov(1'b0);
    repeat (5) @(posedge clk);
    #1 check("latched", {11'h000, latched_off}, 12'h001);
    rd(4'h4, 8'h81, "state");
    rd(4'h1, 8'h0F, "status");
    @(posedge clk) power_cycle <= 1'b1;
    @(posedge clk) power_cycle <= 1'b0;
    rd(4'h4, 8'h40, "state");
    wr(4'h2, 8'h0F);
    repeat (2) @(posedge clk);
    #1 check("irq", {11'h000, irq}, 12'h000);
    rd(4'h1, 8'h00, "status");
  endtask
  task automatic t_hold();
    wr(4'h0, 8'h79);
    pulse_ov(1'b1);
    span(1'b0);
    near("hold1", 20 * CPM + 1);
    span(1'b1);
    near("gap1", 558 * CPM);
    span(1'b0);
    near("hold1", 20 * CPM);
    check("latched", {11'h000, latched_off}, 12'h000);
    pulse_ov(1'b0);
    @(posedge clk) bias_lost <= 1'b1;
    @(posedge clk) bias_lost <= 1'b0;
    #1 check("output", {11'h000, output_en}, 12'h001);
  endtask
  task automatic t_modes();
    wr(4'h0, 8'h00);
    pulse_ov(1'b1);
    repeat (50) @(posedge clk);
    #1 check("ignore", {11'h000, output_en}, 12'h001);
    wr(4'h0, 8'hC0);
    repeat (4) @(posedge clk);
    #1 check("waitclr", {11'h000, output_en}, 12'h000);
    pulse_ov(1'b0);
    repeat (4) @(posedge clk);
    #1 check("waitclr", {11'h000, output_en}, 12'h001);
  endtask
  // no retries latches at once; a frozen clock enable ignores clears and writes; reset clears
  task automatic t_freeze_reset();
    wr(4'h0, 8'h80);
    pulse_ov(1'b1);
    repeat (4) @(posedge clk);
    #1 check("latched", {11'h000, latched_off}, 12'h001);
    @(posedge clk);
    ce <= 1'b0;
    wr(4'h0, 8'h00);
    power_cycle <= 1'b1;
    @(posedge clk);
    power_cycle <= 1'b0;
    ce          <= 1'b1;
    #1 check("frozen", {11'h000, latched_off}, 12'h001);
    rd(4'h0, 8'h80, "action");
    @(posedge clk);
    reset  <= 1'b1;
    ov_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(4'h4, 8'h40, "state");
  endtask
  ////////////////////////////////////////
  // verdict and run control
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_retry_once();
    t_hold();
    t_modes();
    t_freeze_reset();
    end_of_test();
  end
  initial begin
    #(20000 * 100);
    failures++;
    end_of_test();
  end
endmodule
bind oft_retry_timer oft_retry_timer_asserts oft_retry_timer_asserts_inst (.clk(clk),
  .reset(reset), .ce(ce), .bus(bus), .rdata(rdata), .fault_in(fault_in),
  .power_cycle(power_cycle), .bias_lost(bias_lost), .output_en(output_en),
  .latched_off(latched_off), .irq(irq));
